// *** core/ssi_core.sv ***
// Schedule selection and weld initiation with APB register access
`timescale 1ns/1ps

// How it works
// - Mode field: 0 internal, 1 external, 2 two-hand, 3 binary; resets to internal.
// - Internal mode: primary closure starts the displayed schedule.
// - Internal mode: aux A closure starts schedule 20 regardless of display.
// - Internal mode: aux B closure starts schedule 40 regardless of display.
// - External mode: aux levels select 00, 20, 40 or 60 (both closed).
// - External mode: panel selection ignored, only primary closure starts.
// - External with dual schedule: foot switch one runs 00, two runs 10.
// - Two-hand mode: aux pair starts only if both aux close within 0.5 s.
// - Missed window raises dash error, cleared when held inputs release.
// - Two-hand mode: release before squeeze end aborts and retracts.
// - Both hands held until last new-valve squeeze ends, else retract.
// - Two-hand mode: primary or aux pair both start the displayed schedule, or the binary one with option board.
// - Option board caught after reset; with mode 2 enables binary selection.
// - Mode 3 accepted only with option board present.
// - Binary mode: six select inputs give schedule number.
// - Binary mode: primary closure starts selected schedule, panel ignored.
// - Binary mode: aux A still starts 20, aux B still 40.
// - Binary value of 100 or more becomes schedule 99.
module ssi_core
  import ssi_pkg::*;
#(
  parameter int ATD_WINDOW_CYC = ATD_WINDOW_CYC_DFLT,
  parameter int ATD_CNT_W = ATD_CNT_W_DFLT,
  parameter int BIN_SEL_W = BIN_SEL_W_DFLT
)
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [APB_ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic PRIMARY_INITIATE_INPUT_IN,
  input wire logic AUX_INITIATE_SELECT_A_IN,
  input wire logic AUX_INITIATE_SELECT_B_IN,
  input wire logic [BIN_SEL_W-1:0] BINARY_SELECT_INPUTS_IN,
  input wire logic OPTION_PRESENT_IN,
  input wire logic SEQ_ACTIVE_IN,
  input wire logic SQUEEZE_DONE_IN,
  output logic START_OUT,
  output logic [SCHED_W-1:0] START_SCHED_OUT,
  output logic ABORT_OUT,
  output logic DASH_ERROR_OUT
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int PIN_W = BIN_SEL_W + 4;

  typedef struct packed {
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic [PIN_W-1:0] pin_d;
    logic [1:0] boot_cnt;
    logic opt_present;
    logic [1:0] mode;
    logic dual_sched;
    logic [SCHED_W-1:0] disp_sched;
    ssi_atd_t atd;
    logic [ATD_CNT_W-1:0] atd_cnt;
    logic dash_err;
    logic start;
    logic [SCHED_W-1:0] start_sched;
    logic abort;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ssi_state_t;

  ssi_state_t s_reg;
  ssi_state_t s_next;

  // Binary select value clamped to the highest schedule
  function automatic logic [SCHED_W-1:0] sched_clamp(input logic [BIN_SEL_W-1:0] v);
    int unsigned val;
    val = int'(v);
    if (val >= SCHED_LIMIT)
      sched_clamp = SCHED_99;
    else
      sched_clamp = SCHED_W'(val);
  endfunction

  // Synchronised levels and closure edges
  logic prim_lvl;
  logic a_lvl;
  logic b_lvl;
  logic opt_lvl;
  logic [BIN_SEL_W-1:0] bin_lvl;
  logic prim_edge;
  logic a_edge;
  logic b_edge;
  logic binary_en;
  logic [SCHED_W-1:0] atd_sched;
  logic [SCHED_W-1:0] ext_sched;
  logic setup_phase;
  logic write_now;

  assign prim_lvl = s_reg.pin_s2[0];
  assign a_lvl = s_reg.pin_s2[1];
  assign b_lvl = s_reg.pin_s2[2];
  assign bin_lvl = s_reg.pin_s2[3 +: BIN_SEL_W];
  assign opt_lvl = s_reg.pin_s2[PIN_W-1];
  assign prim_edge = prim_lvl & ~s_reg.pin_d[0];
  assign a_edge = a_lvl & ~s_reg.pin_d[1];
  assign b_edge = b_lvl & ~s_reg.pin_d[2];
  assign binary_en = s_reg.opt_present && (s_reg.mode == MODE_ATD);
  assign atd_sched = binary_en ? sched_clamp(bin_lvl) : s_reg.disp_sched;
  assign setup_phase = PSEL_IN & ~PENABLE_IN;
  assign write_now = PSEL_IN & PENABLE_IN & s_reg.pready & PWRITE_IN;

  // ----------------------------------------------------------------
  // External select decode
  // ----------------------------------------------------------------
  always_comb
  begin
    ext_sched = SCHED_00;
    if (s_reg.dual_sched)
      ext_sched = a_lvl ? SCHED_10 : SCHED_00;
    else
    begin
      case ({b_lvl, a_lvl})
        2'b00: ext_sched = SCHED_00;
        2'b01: ext_sched = SCHED_20;
        2'b10: ext_sched = SCHED_40;
        2'b11: ext_sched = SCHED_60;
        default: ext_sched = SCHED_00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.pin_s1 = {OPTION_PRESENT_IN, BINARY_SELECT_INPUTS_IN, AUX_INITIATE_SELECT_B_IN,
                     AUX_INITIATE_SELECT_A_IN, PRIMARY_INITIATE_INPUT_IN};
    s_next.pin_s2 = s_reg.pin_s1;
    s_next.pin_d = s_reg.pin_s2;
    s_next.start = 1'b0;
    s_next.abort = 1'b0;
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;

    // Option strap caught once after synchroniser settles
    if (s_reg.boot_cnt != OPT_CAPTURE_CNT)
    begin
      s_next.boot_cnt = s_reg.boot_cnt + 2'h1;
      if (s_reg.boot_cnt == OPT_CAPTURE_CNT - 2'h1)
        s_next.opt_present = opt_lvl;
    end

    // Initiation per mode
    if (!SEQ_ACTIVE_IN)
    begin
      case (s_reg.mode)
        MODE_INTERNAL:
          if (prim_edge)
            {s_next.start, s_next.start_sched} = {1'b1, s_reg.disp_sched};
          else if (a_edge)
            {s_next.start, s_next.start_sched} = {1'b1, SCHED_20};
          else if (b_edge)
            {s_next.start, s_next.start_sched} = {1'b1, SCHED_40};
        MODE_EXTERNAL:
          if (prim_edge)
            {s_next.start, s_next.start_sched} = {1'b1, ext_sched};
        MODE_ATD:
          if (prim_edge && s_reg.atd == ATD_IDLE && !a_lvl && !b_lvl)
            {s_next.start, s_next.start_sched} = {1'b1, atd_sched};
        MODE_BINARY:
          if (prim_edge)
            {s_next.start, s_next.start_sched} = {1'b1, sched_clamp(bin_lvl)};
          else if (a_edge)
            {s_next.start, s_next.start_sched} = {1'b1, SCHED_20};
          else if (b_edge)
            {s_next.start, s_next.start_sched} = {1'b1, SCHED_40};
        default:
          s_next.start = 1'b0;
      endcase
    end

    // Two-hand coincidence and hold supervision
    if (s_reg.mode != MODE_ATD)
    begin
      s_next.atd = ATD_IDLE;
      s_next.dash_err = 1'b0;
    end
    else
    begin
      case (s_reg.atd)
        ATD_IDLE:
        begin
          s_next.atd_cnt = '0;
          if (a_lvl && b_lvl && !SEQ_ACTIVE_IN && !prim_edge)
          begin
            s_next.start = 1'b1;
            s_next.start_sched = atd_sched;
            s_next.atd = ATD_HOLD;
          end
          else if ((a_lvl || b_lvl) && !SEQ_ACTIVE_IN)
            s_next.atd = ATD_WAIT;
        end
        ATD_WAIT:
        begin
          if (a_lvl && b_lvl)
          begin
            s_next.start = 1'b1;
            s_next.start_sched = atd_sched;
            s_next.atd = ATD_HOLD;
          end
          else if (!a_lvl && !b_lvl)
            s_next.atd = ATD_IDLE;
          else if (s_reg.atd_cnt == ATD_CNT_W'(ATD_WINDOW_CYC - 1))
          begin
            s_next.dash_err = 1'b1;
            s_next.atd = ATD_REL;
          end
          else
            s_next.atd_cnt = s_reg.atd_cnt + 1'b1;
        end
        ATD_HOLD:
        begin
          if (SQUEEZE_DONE_IN)
            s_next.atd = ATD_REL;
          else if (!a_lvl || !b_lvl)
          begin
            s_next.abort = 1'b1;
            s_next.atd = ATD_REL;
          end
        end
        ATD_REL:
        begin
          if (!a_lvl && !b_lvl)
          begin
            s_next.dash_err = 1'b0;
            s_next.atd = ATD_IDLE;
          end
        end
        default:
          s_next.atd = ATD_IDLE;
      endcase
    end

    // APB read data and error prepared in setup phase
    if (setup_phase)
    begin
      s_next.pready = 1'b1;
      s_next.prdata = '0;
      case (PADDR_IN)
        OFF_CTRL:
        begin
          s_next.prdata[CTRL_MODE_LSB +: 2] = s_reg.mode;
          s_next.prdata[CTRL_DUAL_BIT] = s_reg.dual_sched;
        end
        OFF_DISP_SCHED:
          s_next.prdata[SCHED_W-1:0] = s_reg.disp_sched;
        OFF_STATUS:
        begin
          s_next.prdata[STAT_ERR_BIT] = s_reg.dash_err;
          s_next.prdata[STAT_OPT_BIT] = s_reg.opt_present;
          s_next.prdata[STAT_BINEN_BIT] = binary_en;
          s_next.prdata[STAT_ATD_BUSY_BIT] = (s_reg.atd != ATD_IDLE);
          s_next.prdata[STAT_SCHED_LSB +: SCHED_W] = s_reg.start_sched;
        end
        default:
          s_next.pslverr = 1'b1;
      endcase
    end

    // APB writes take effect at the completing edge
    if (write_now)
    begin
      case (PADDR_IN)
        OFF_CTRL:
        begin
          if (PWDATA_IN[CTRL_MODE_LSB +: 2] != MODE_BINARY || s_reg.opt_present)
            s_next.mode = PWDATA_IN[CTRL_MODE_LSB +: 2];
          s_next.dual_sched = PWDATA_IN[CTRL_DUAL_BIT];
        end
        OFF_DISP_SCHED:
        begin
          if (s_reg.mode != MODE_EXTERNAL && s_reg.mode != MODE_BINARY)
            s_next.disp_sched = (PWDATA_IN[SCHED_W-1:0] >= SCHED_W'(SCHED_LIMIT)) ? SCHED_99 : PWDATA_IN[SCHED_W-1:0];
        end
        default:
          s_next.pslverr = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign PRDATA_OUT = s_reg.prdata;
  assign PREADY_OUT = s_reg.pready;
  assign PSLVERR_OUT = s_reg.pslverr;
  assign START_OUT = s_reg.start;
  assign START_SCHED_OUT = s_reg.start_sched;
  assign ABORT_OUT = s_reg.abort;
  assign DASH_ERROR_OUT = s_reg.dash_err;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  sequence s_int_idle;
    s_reg.mode == MODE_INTERNAL && !SEQ_ACTIVE_IN;
  endsequence

  property p_int_primary;
    s_int_idle and prim_edge |=> START_OUT && START_SCHED_OUT == $past(s_reg.disp_sched);
  endproperty
  a_int_primary: assert property (p_int_primary) else $error("primary start wrong schedule");

  property p_int_aux_a;
    s_int_idle and (a_edge && !prim_edge) |=> START_OUT && START_SCHED_OUT == SCHED_20;
  endproperty
  a_int_aux_a: assert property (p_int_aux_a) else $error("aux A did not start 20");

  property p_int_aux_b;
    s_int_idle and (b_edge && !a_edge && !prim_edge) |=> START_OUT && START_SCHED_OUT == SCHED_40;
  endproperty
  a_int_aux_b: assert property (p_int_aux_b) else $error("aux B did not start 40");

  property p_ext_select;
    s_reg.mode == MODE_EXTERNAL && !s_reg.dual_sched && !SEQ_ACTIVE_IN && prim_edge && a_lvl && b_lvl
      |=> START_OUT && START_SCHED_OUT == SCHED_60;
  endproperty
  a_ext_select: assert property (p_ext_select) else $error("external select not 60");

  property p_ext_aux_ignored;
    s_reg.mode == MODE_EXTERNAL && !prim_edge |=> !START_OUT;
  endproperty
  a_ext_aux_ignored: assert property (p_ext_aux_ignored) else $error("external start without primary");

  property p_dual;
    s_reg.mode == MODE_EXTERNAL && s_reg.dual_sched && !SEQ_ACTIVE_IN && prim_edge && !a_lvl
      |=> START_SCHED_OUT == SCHED_00;
  endproperty
  a_dual: assert property (p_dual) else $error("foot switch one not 00");

  sequence s_window_missed;
    s_reg.atd == ATD_WAIT && s_reg.atd_cnt == ATD_CNT_W'(ATD_WINDOW_CYC - 1) && (a_lvl ^ b_lvl);
  endsequence

  property p_window_error;
    s_reg.mode == MODE_ATD ##0 s_window_missed |=> DASH_ERROR_OUT && !START_OUT;
  endproperty
  a_window_error: assert property (p_window_error) else $error("missed window not flagged");

  property p_err_clear;
    DASH_ERROR_OUT && s_reg.mode == MODE_ATD && !a_lvl && !b_lvl |=> !DASH_ERROR_OUT;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("dash error not cleared");

  property p_abort;
    s_reg.mode == MODE_ATD && s_reg.atd == ATD_HOLD && !SQUEEZE_DONE_IN && !(a_lvl && b_lvl)
      |=> ABORT_OUT ##1 !ABORT_OUT;
  endproperty
  a_abort: assert property (p_abort) else $error("early release did not abort");

  property p_mode3_refused;
    write_now && PADDR_IN == OFF_CTRL && PWDATA_IN[CTRL_MODE_LSB +: 2] == MODE_BINARY && !s_reg.opt_present
      |=> $stable(s_reg.mode);
  endproperty
  a_mode3_refused: assert property (p_mode3_refused) else $error("mode 3 accepted without option");

  property p_binary_sched;
    s_reg.mode == MODE_BINARY && !SEQ_ACTIVE_IN && prim_edge |=> START_SCHED_OUT == sched_clamp($past(bin_lvl));
  endproperty
  a_binary_sched: assert property (p_binary_sched) else $error("binary schedule wrong");

endmodule

// *** core/ssi_pkg.sv ***
// Constants, register map and types for schedule selection and initiation
package ssi_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50000000;
  localparam int ATD_WINDOW_MS = 500;
  localparam int ATD_WINDOW_CYC_DFLT = (CLK_HZ / 1000) * ATD_WINDOW_MS;
  localparam int ATD_CNT_W_DFLT = 25;
  localparam logic [1:0] OPT_CAPTURE_CNT = 2'h3;

  // ----------------------------------------------------------------
  // Schedule numbers
  // ----------------------------------------------------------------
  localparam int SCHED_W = 7;
  localparam int BIN_SEL_W_DFLT = 6;
  localparam logic [SCHED_W-1:0] SCHED_00 = 7'h00;
  localparam logic [SCHED_W-1:0] SCHED_10 = 7'h0A;
  localparam logic [SCHED_W-1:0] SCHED_20 = 7'h14;
  localparam logic [SCHED_W-1:0] SCHED_40 = 7'h28;
  localparam logic [SCHED_W-1:0] SCHED_60 = 7'h3C;
  localparam logic [SCHED_W-1:0] SCHED_99 = 7'h63;
  localparam int SCHED_LIMIT = 100;

  // ----------------------------------------------------------------
  // Schedule select modes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_INTERNAL = 2'h0;
  localparam logic [1:0] MODE_EXTERNAL = 2'h1;
  localparam logic [1:0] MODE_ATD = 2'h2;
  localparam logic [1:0] MODE_BINARY = 2'h3;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int APB_ADDR_W = 12;
  localparam logic [APB_ADDR_W-1:0] OFF_CTRL = 12'h000;
  localparam logic [APB_ADDR_W-1:0] OFF_DISP_SCHED = 12'h004;
  localparam logic [APB_ADDR_W-1:0] OFF_STATUS = 12'h008;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DUAL_BIT = 2;
  localparam int STAT_ERR_BIT = 0;
  localparam int STAT_OPT_BIT = 1;
  localparam int STAT_BINEN_BIT = 2;
  localparam int STAT_ATD_BUSY_BIT = 3;
  localparam int STAT_SCHED_LSB = 8;

  // ----------------------------------------------------------------
  // Two-hand initiation states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ATD_IDLE = 2'b00,
    ATD_WAIT = 2'b01,
    ATD_HOLD = 2'b10,
    ATD_REL = 2'b11
  } ssi_atd_t;

endpackage

// *** tb/ssi_switch_model.sv ***
// Operator switch model driving the initiation pins
`timescale 1ns/1ps
module ssi_switch_model
  import ssi_pkg::*;
#(
  parameter int BW = 6
)
(
  input wire logic clk_in,
  output logic prim_out,
  output logic sel_a_out,
  output logic sel_b_out,
  output logic [BW-1:0] bin_out
);
  initial
  begin
    prim_out = 1'b0;
    sel_a_out = 1'b0;
    sel_b_out = 1'b0;
    bin_out = '0;
  end

  task automatic levels(input logic a, input logic b, input logic [BW-1:0] v);
    @(posedge clk_in);
    sel_a_out <= a;
    sel_b_out <= b;
    bin_out <= v;
  endtask

  // Selects settle for three cycles before the primary contact closes
  task automatic fire();
    repeat (3) @(posedge clk_in);
    prim_out <= 1'b1;
  endtask

  // Selects held past the start, then all contacts open
  task automatic open_all();
    @(posedge clk_in);
    prim_out <= 1'b0;
    repeat (2) @(posedge clk_in);
    sel_a_out <= 1'b0;
    sel_b_out <= 1'b0;
    bin_out <= '0;
  endtask
endmodule

// *** tb/test_schedule_select_initiation.sv ***
// Self-checking testbench for schedule selection and initiation
`timescale 1ns/1ps
module test_schedule_select_initiation;
  import ssi_pkg::*;
  localparam int WIN = 50;
  localparam int BW = 7;
  localparam int LIMIT = 20000;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, prim, aux_a, aux_b, opt, seq_act, sq_done;
  logic start, abort_p, dash, err, seen;
  logic [APB_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [BW-1:0] bin;
  logic [BW-1:0] corner [3] = '{7'h63, 7'h64, 7'h7F};
  logic [SCHED_W-1:0] sched, disp;
  int n_fail, cmp_count, cyc, i;

  ssi_core #(.ATD_WINDOW_CYC(WIN), .BIN_SEL_W(BW)) dut (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PRIMARY_INITIATE_INPUT_IN(prim),
    .AUX_INITIATE_SELECT_A_IN(aux_a), .AUX_INITIATE_SELECT_B_IN(aux_b), .BINARY_SELECT_INPUTS_IN(bin),
    .OPTION_PRESENT_IN(opt), .SEQ_ACTIVE_IN(seq_act), .SQUEEZE_DONE_IN(sq_done), .START_OUT(start),
    .START_SCHED_OUT(sched), .ABORT_OUT(abort_p), .DASH_ERROR_OUT(dash));

  ssi_switch_model #(.BW(BW)) sw (.clk_in(clk), .prim_out(prim), .sel_a_out(aux_a), .sel_b_out(aux_b),
    .bin_out(bin));

  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      n_fail++;
      results();
    end
  end

  function automatic logic [SCHED_W-1:0] exp_ext(input int k);
    case (k)
      0: return SCHED_00;
      1: return SCHED_20;
      2: return SCHED_40;
      default: return SCHED_60;
    endcase
  endfunction

  function automatic logic [SCHED_W-1:0] exp_bin(input logic [BW-1:0] v);
    return (v >= SCHED_LIMIT) ? SCHED_99 : SCHED_W'(v);
  endfunction

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [APB_ADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic expect_start(input logic [SCHED_W-1:0] exp, input string what);
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      #1;
      k++;
    end
    while (start !== 1'b1 && k < 12);
    check(what, {24'h0, start, sched}, {24'h0, 1'b1, exp});
  endtask

  task automatic no_start(input int n, input string what);
    seen = 1'b0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      if (start === 1'b1) seen = 1'b1;
    end
    check(what, {31'h0, seen}, 32'h0);
  endtask

  task automatic watch_abort(input int n);
    seen = 1'b0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      if (abort_p === 1'b1) seen = 1'b1;
    end
  endtask

  task automatic release_all();
    sw.open_all();
    repeat (4) @(posedge clk);
  endtask

  task automatic do_reset(input logic v);
    @(posedge clk);
    rst <= 1'b1;
    opt <= v;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rst, opt, seq_act, sq_done, psel, penable, pwrite} = 7'h41;
    paddr = '0;
    pwdata = '0;
    n_fail = 0;
    cmp_count = 0;
    void'($urandom(45));
    do_reset(1'b0);
    apb(1'b0, OFF_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h3);
    apb(1'b0, OFF_CTRL, 32'h0);
    check("mode 3 without option", rd, 32'h0);
    apb(1'b0, 12'h0FC, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    disp = SCHED_W'($urandom_range(99, 0));
    apb(1'b1, OFF_DISP_SCHED, {25'h0, disp});
    apb(1'b1, OFF_CTRL, {30'h0, MODE_ATD});
    sw.levels(1'b1, 1'b0, '0);
    repeat ($urandom_range(40, 0)) @(posedge clk);
    sw.levels(1'b1, 1'b1, '0);
    expect_start(disp, "two-hand start");
    sw.levels(1'b0, 1'b1, '0);
    watch_abort(10);
    check("early release abort", {31'h0, seen}, 32'h1);
    release_all();
    sw.levels(1'b1, 1'b1, '0);
    expect_start(disp, "two-hand together");
    @(posedge clk);
    sq_done <= 1'b1;
    @(posedge clk);
    sq_done <= 1'b0;
    sw.open_all();
    watch_abort(8);
    check("release after squeeze", {31'h0, seen}, 32'h0);
    repeat (4) @(posedge clk);
    sw.levels(1'b1, 1'b0, '0);
    repeat (WIN + 20) @(posedge clk);
    check("dash error set", {31'h0, dash}, 32'h1);
    sw.levels(1'b1, 1'b1, '0);
    no_start(8, "late pair refused");
    release_all();
    repeat (4) @(posedge clk);
    check("dash error cleared", {31'h0, dash}, 32'h0);
    sw.fire();
    expect_start(disp, "two-hand primary");
    release_all();

    do_reset(1'b1);
    disp = SCHED_W'($urandom_range(99, 0));
    apb(1'b1, OFF_DISP_SCHED, {25'h0, disp});
    sw.fire();
    expect_start(disp, "internal primary");
    release_all();
    sw.levels(1'b1, 1'b0, '0);
    expect_start(SCHED_20, "internal aux a");
    release_all();
    sw.levels(1'b0, 1'b1, '0);
    expect_start(SCHED_40, "internal aux b");
    release_all();
    seq_act <= 1'b1;
    sw.fire();
    no_start(8, "busy sequencer");
    release_all();
    seq_act <= 1'b0;
    apb(1'b1, OFF_CTRL, {30'h0, MODE_EXTERNAL});
    apb(1'b1, OFF_DISP_SCHED, {25'h0, disp + 7'h1});
    apb(1'b0, OFF_DISP_SCHED, 32'h0);
    check("panel ignored external", rd, {25'h0, disp});
    for (i = 0; i < 4; i++)
    begin
      sw.levels(i[0], i[1], '0);
      no_start(6, "external aux no start");
      sw.fire();
      expect_start(exp_ext(i), "external select");
      release_all();
    end
    apb(1'b1, OFF_CTRL, {29'h0, 1'b1, MODE_EXTERNAL});
    for (i = 0; i < 2; i++)
    begin
      sw.levels(i[0], 1'b0, '0);
      sw.fire();
      expect_start(i[0] ? SCHED_10 : SCHED_00, "dual foot switch");
      release_all();
    end
    apb(1'b1, OFF_CTRL, {30'h0, MODE_ATD});
    apb(1'b0, OFF_STATUS, 32'h0);
    check("binary in two-hand", {31'h0, rd[STAT_BINEN_BIT]}, 32'h1);
    sw.levels(1'b1, 1'b1, 7'h2D);
    expect_start(7'h2D, "two-hand binary");
    release_all();
    apb(1'b1, OFF_CTRL, {30'h0, MODE_BINARY});
    apb(1'b0, OFF_CTRL, 32'h0);
    check("mode 3 with option", rd, {30'h0, MODE_BINARY});
    apb(1'b1, OFF_DISP_SCHED, {25'h0, disp + 7'h2});
    apb(1'b0, OFF_DISP_SCHED, 32'h0);
    check("panel ignored binary", rd, {25'h0, disp});
    for (i = 0; i < 8; i++)
    begin
      sw.levels(1'b0, 1'b0, (i < 3) ? corner[i] : BW'($urandom_range(127, 0)));
      sw.fire();
      @(posedge clk);
      expect_start(exp_bin(bin), "binary select");
      release_all();
    end
    sw.levels(1'b1, 1'b0, 7'h05);
    expect_start(SCHED_20, "binary aux a");
    release_all();
    sw.levels(1'b0, 1'b1, 7'h05);
    expect_start(SCHED_40, "binary aux b");
    release_all();
    results();
  end
endmodule
